// >>> hw/asl_unit.sv
// asl_unit: 32-bit accumulator with eight-level push-down stack
// assumes the instruction sequencer issues one op at a time on the core
// clock and a word memory whose data follows the registered address in
// the strobe cycle and holds the last strobed word until the next strobe
//
// Contract
// RULE_01 - 32-bit accumulator holds working data
// RULE_02 - accumulator holds BCD or two's complement
// RULE_03 - accumulator cleared at end of scan
// RULE_04 - later loads push old accumulator first
// RULE_05 - output cancels pending push on next load
// RULE_06 - eight-entry stack, push shifts entries down
// RULE_07 - push with full stack drops bottom
// RULE_08 - pop moves top into accumulator, shifts up
// RULE_09 - manipulation result replaces accumulator value
// RULE_10 - single-word load zeroes upper sixteen bits
// RULE_11 - double-word load fills all 32 bits
// RULE_12 - 32-bit transfer uses two consecutive words
// RULE_13 - zero flag set when load gives zero
// RULE_14 - pointer word read as binary address
// RULE_15 - pointer load fetches referenced word low
// RULE_16 - pop on empty stack loads zero
`timescale 1ns/10ps
module asl_unit
  import asl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_op_valid,
  input wire asl_op_t i_op,
  input wire logic [ASL_ADDR_W-1:0] i_addr,
  input wire logic [ASL_ACC_W-1:0] i_const,
  input wire logic [ASL_ACC_W-1:0] i_result,
  output logic o_op_ready,
  output logic o_op_done,
  output logic o_mem_rd,
  output logic [ASL_ADDR_W-1:0] o_mem_addr,
  input wire logic [ASL_WORD_W-1:0] i_mem_rdata,
  output logic [ASL_ACC_W-1:0] o_acc,
  output logic [ASL_ACC_W-1:0] o_stack_top,
  output logic [ASL_LVL_W-1:0] o_stack_level,
  output logic o_accumulator_zero_flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  asl_state_t state_q;
  asl_op_t op_q;
  logic [ASL_ACC_W-1:0] acc_q; // bcd or binary, no interpretation here
  logic [ASL_ACC_W-1:0] stack_q [ASL_STACK_DEPTH];
  logic [ASL_LVL_W-1:0] level_q;
  logic loaded_q; // a load since scan start or last output
  logic zflag_q;
  logic [ASL_ADDR_W-1:0] addr_q;
  logic [ASL_WORD_W-1:0] lo_q;

  // commit strobes, derived from state
  logic load_commit;
  logic [ASL_ACC_W-1:0] load_value;
  logic do_push;
  logic pop_now;
  logic idle_take;
  logic is_load;

  // ----------------------------------------------------------------
  // operation classification
  // ----------------------------------------------------------------
  always_comb begin
    case (i_op)
      ASL_OP_LOAD_SINGLE_WORD,
      ASL_OP_LOAD_CONST,
      ASL_OP_LOAD_DOUBLE,
      ASL_OP_LOAD_DOUBLE_CONST,
      ASL_OP_LOAD_POINTER,
      ASL_OP_OCTAL_ADDRESS_TO_HEX_LOAD: is_load = 1'b1;
      default: is_load = 1'b0;
    endcase
  end

  assign o_op_ready = (state_q == ASL_ST_IDLE);
  assign idle_take = o_op_ready && i_op_valid;
  assign load_commit = (state_q == ASL_ST_COMMIT);
  assign pop_now = idle_take && (i_op == ASL_OP_POP);
  // only a load after a previous un-output load pushes
  assign do_push = load_commit && loaded_q; // RULE_04 RULE_05

  // ----------------------------------------------------------------
  // octal-to-binary conversion: each 3-bit digit packed densely
  // the printed address is entered as hex digits 0..7 per nibble
  // ----------------------------------------------------------------
  function automatic logic [ASL_WORD_W-1:0] asl_oct_to_bin(
    input logic [ASL_ACC_W-1:0] oct
  );
    logic [ASL_WORD_W-1:0] res;
    res = ASL_WORD_ZERO;
    for (int i = 0; i < 6; i++) begin
      res = res | (ASL_WORD_W'({29'h0, oct[4*i +: 3]}) << (3*i));
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // value committed by the current load
  // ----------------------------------------------------------------
  always_comb begin
    case (op_q)
      ASL_OP_LOAD_DOUBLE:
        load_value = {i_mem_rdata, lo_q}; // RULE_11 RULE_12
      ASL_OP_LOAD_DOUBLE_CONST:
        load_value = i_const; // RULE_11
      ASL_OP_LOAD_CONST:
        load_value = {ASL_WORD_ZERO, i_const[ASL_WORD_W-1:0]}; // RULE_10
      ASL_OP_OCTAL_ADDRESS_TO_HEX_LOAD:
        load_value = {ASL_WORD_ZERO, asl_oct_to_bin(i_const)}; // RULE_14
      default:
        load_value = {ASL_WORD_ZERO, i_mem_rdata}; // RULE_10 RULE_15
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer: single-word loads take a read step, double and pointer loads two,
  // constant loads commit one cycle after acceptance
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ASL_ST_IDLE;
      op_q <= ASL_OP_NONE;
      addr_q <= ASL_WORD_ZERO;
      lo_q <= ASL_WORD_ZERO;
    end else begin
      case (state_q)
        ASL_ST_IDLE: begin
          if (idle_take && is_load) begin
            op_q <= i_op;
            addr_q <= i_addr;
            case (i_op)
              ASL_OP_LOAD_SINGLE_WORD: state_q <= ASL_ST_RD_LO;
              ASL_OP_LOAD_DOUBLE: state_q <= ASL_ST_RD_LO;
              ASL_OP_LOAD_POINTER: state_q <= ASL_ST_RD_PTR;
              default: state_q <= ASL_ST_COMMIT;
            endcase
          end
        end
        ASL_ST_RD_PTR: begin
          // pointer contents are a plain binary address
          addr_q <= i_mem_rdata; // RULE_14 RULE_15
          state_q <= ASL_ST_RD_LO;
        end
        ASL_ST_RD_LO: begin
          lo_q <= i_mem_rdata;
          if (op_q == ASL_OP_LOAD_DOUBLE) begin
            addr_q <= addr_q + ASL_ADDR_ONE; // RULE_12
            state_q <= ASL_ST_RD_HI;
          end else begin
            state_q <= ASL_ST_COMMIT;
          end
        end
        ASL_ST_RD_HI: state_q <= ASL_ST_COMMIT;
        ASL_ST_COMMIT: state_q <= ASL_ST_IDLE;
        default: state_q <= ASL_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory read strobe: data returns one cycle later, so the read
  // issued in a state is consumed in the following state
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mem_rd <= 1'b0;
      o_mem_addr <= ASL_WORD_ZERO;
    end else if (idle_take && (i_op == ASL_OP_LOAD_SINGLE_WORD ||
                 i_op == ASL_OP_LOAD_DOUBLE ||
                 i_op == ASL_OP_LOAD_POINTER)) begin
      o_mem_rd <= 1'b1;
      o_mem_addr <= i_addr;
    end else if (state_q == ASL_ST_RD_PTR) begin
      o_mem_rd <= 1'b1;
      o_mem_addr <= i_mem_rdata; // RULE_15
    end else if (state_q == ASL_ST_RD_LO && op_q == ASL_OP_LOAD_DOUBLE) begin
      o_mem_rd <= 1'b1;
      o_mem_addr <= addr_q + ASL_ADDR_ONE; // RULE_12
    end else begin
      o_mem_rd <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // accumulator: end of scan has priority, it empties the accumulator but leaves the stack
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_q <= ASL_ACC_ZERO;
    end else if (idle_take && i_op == ASL_OP_END_SCAN) begin
      acc_q <= ASL_ACC_ZERO; // RULE_03
    end else if (load_commit) begin
      acc_q <= load_value; // RULE_01 RULE_02
    end else if (pop_now) begin
      acc_q <= stack_q[0]; // RULE_08 RULE_16
    end else if (idle_take && i_op == ASL_OP_RESULT) begin
      acc_q <= i_result; // RULE_09
    end
  end

  // ----------------------------------------------------------------
  // push-down stack; empty slots hold zero so a pop past the last
  // pushed value returns zero
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < ASL_STACK_DEPTH; i++) begin
        stack_q[i] <= ASL_ACC_ZERO;
      end
      level_q <= ASL_LVL_ZERO;
    end else if (do_push) begin
      // bottom entry falls off when all eight are in use
      for (int i = ASL_STACK_DEPTH-1; i > 0; i--) begin
        stack_q[i] <= stack_q[i-1]; // RULE_06 RULE_07
      end
      stack_q[0] <= acc_q; // RULE_04
      if (level_q != ASL_LVL_FULL) begin
        level_q <= level_q + ASL_LVL_ONE;
      end
    end else if (pop_now) begin
      for (int i = 0; i < ASL_STACK_DEPTH-1; i++) begin
        stack_q[i] <= stack_q[i+1]; // RULE_08
      end
      stack_q[ASL_STACK_DEPTH-1] <= ASL_ACC_ZERO; // RULE_16
      if (level_q != ASL_LVL_ZERO) begin
        level_q <= level_q - ASL_LVL_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // push-pending tracking: set by a load, cleared by output or scan end
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      loaded_q <= 1'b0;
    end else if (load_commit) begin
      loaded_q <= 1'b1; // RULE_04
    end else if (idle_take &&
                 (i_op == ASL_OP_OUTPUT || i_op == ASL_OP_END_SCAN)) begin
      loaded_q <= 1'b0; // RULE_05 RULE_03
    end
  end

  // ----------------------------------------------------------------
  // zero flag reflects the value of the most recent load
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      zflag_q <= 1'b0;
    end else if (load_commit) begin
      zflag_q <= (load_value == ASL_ACC_ZERO); // RULE_13
    end
  end

  // ----------------------------------------------------------------
  // done pulse for any op, registered
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_op_done <= 1'b0;
    end else begin
      o_op_done <= load_commit || (idle_take && !is_load);
    end
  end

  assign o_acc = acc_q;
  assign o_stack_top = stack_q[0];
  assign o_stack_level = level_q;
  assign o_accumulator_zero_flag = zflag_q;

endmodule

// >>> shared/asl_pkg.sv
// asl_pkg: constants and types shared by the accumulator/stack load unit
// assumes a single 100 MHz core clock domain
package asl_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int ASL_ACC_W = 32;
  localparam int ASL_WORD_W = 16;
  localparam int ASL_STACK_DEPTH = 8;
  localparam int ASL_LVL_W = 4;
  localparam int ASL_ADDR_W = 16;

  localparam logic [ASL_WORD_W-1:0] ASL_WORD_ZERO = 16'h0000;
  localparam logic [ASL_ACC_W-1:0] ASL_ACC_ZERO = 32'h0000_0000;
  localparam logic [ASL_LVL_W-1:0] ASL_LVL_ZERO = 4'h0;
  localparam logic [ASL_LVL_W-1:0] ASL_LVL_ONE = 4'h1;
  localparam logic [ASL_LVL_W-1:0] ASL_LVL_FULL = 4'h8;
  localparam logic [ASL_ADDR_W-1:0] ASL_ADDR_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // operation codes from the instruction sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASL_OP_NONE = 4'h0,
    ASL_OP_LOAD_SINGLE_WORD = 4'h1, // load word from memory
    ASL_OP_LOAD_CONST = 4'h2, // load 16-bit constant
    ASL_OP_LOAD_DOUBLE = 4'h3, // load two consecutive words
    ASL_OP_LOAD_DOUBLE_CONST = 4'h4, // load 32-bit constant
    ASL_OP_LOAD_POINTER = 4'h5, // load via pointer word
    ASL_OP_OCTAL_ADDRESS_TO_HEX_LOAD = 4'h6, // octal address to binary
    ASL_OP_OUTPUT = 4'h7, // output operation, cancels push
    ASL_OP_POP = 4'h8,
    ASL_OP_RESULT = 4'h9, // manipulation result replaces acc
    ASL_OP_END_SCAN = 4'hA
  } asl_op_t;

  // ----------------------------------------------------------------
  // sequencer states (one-hot)
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ASL_ST_IDLE = 5'b00001,
    ASL_ST_RD_LO = 5'b00010,
    ASL_ST_RD_HI = 5'b00100,
    ASL_ST_RD_PTR = 5'b01000,
    ASL_ST_COMMIT = 5'b10000
  } asl_state_t;

endpackage

// >>> tb/asl_unit_chk.sv
// checker for the accumulator/stack load unit, bound to its top
// assumes one clock domain and the one-op-at-a-time sequencer contract
`timescale 1ns/10ps
module asl_unit_chk
  import asl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_op_valid,
  input wire asl_op_t i_op,
  input wire logic [ASL_ADDR_W-1:0] i_addr,
  input wire logic [ASL_ACC_W-1:0] i_const,
  input wire logic [ASL_ACC_W-1:0] i_result,
  input wire logic o_op_ready,
  input wire logic o_op_done,
  input wire logic o_mem_rd,
  input wire logic [ASL_ADDR_W-1:0] o_mem_addr,
  input wire logic [ASL_WORD_W-1:0] i_mem_rdata,
  input wire logic [ASL_ACC_W-1:0] o_acc,
  input wire logic [ASL_ACC_W-1:0] o_stack_top,
  input wire logic [ASL_LVL_W-1:0] o_stack_level,
  input wire logic o_accumulator_zero_flag
);
  logic ld_q;
  logic [ASL_ADDR_W-1:0] a_q;
  wire tk = i_op_valid && o_op_ready;
  wire isld = tk && i_op >= ASL_OP_LOAD_SINGLE_WORD &&
    i_op <= ASL_OP_OCTAL_ADDRESS_TO_HEX_LOAD;
  // ----------------------------------------------------------------
  // helper: remember a load in flight and its base address
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ld_q <= 1'b0;
      a_q <= '0;
    end else if (isld) begin
      ld_q <= 1'b1;
      a_q <= i_addr;
    end else if (o_op_done) begin
      ld_q <= 1'b0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_take(asl_op_t o);
    tk && i_op == o;
  endsequence
  sequence s_hi_rd;
    o_mem_rd && o_mem_addr == a_q + ASL_ADDR_ONE;
  endsequence
  property p_end_scan;
    s_take(ASL_OP_END_SCAN) |=> o_acc == ASL_ACC_ZERO && o_op_done;
  endproperty
  property p_result;
    s_take(ASL_OP_RESULT) |=> o_acc == $past(i_result);
  endproperty
  property p_pop;
    s_take(ASL_OP_POP) |=> o_acc == $past(o_stack_top);
  endproperty
  property p_pop_lvl;
    s_take(ASL_OP_POP) |=> o_stack_level ==
      (($past(o_stack_level) == ASL_LVL_ZERO) ? ASL_LVL_ZERO :
       $past(o_stack_level) - ASL_LVL_ONE);
  endproperty
  property p_single;
    s_take(ASL_OP_LOAD_SINGLE_WORD) |=> o_mem_rd &&
      o_mem_addr == $past(i_addr) ##2 o_op_done &&
      o_acc[31:16] == ASL_WORD_ZERO;
  endproperty
  property p_dbl;
    s_take(ASL_OP_LOAD_DOUBLE) |=> o_mem_rd ##[1:2] s_hi_rd;
  endproperty
  property p_zero;
    o_op_done && ld_q |->
      o_accumulator_zero_flag == (o_acc == ASL_ACC_ZERO);
  endproperty
  property p_lvl;
    o_stack_level <= ASL_LVL_FULL;
  endproperty
  property p_ld_done;
    isld |=> !o_op_ready ##[1:3] o_op_done;
  endproperty
  a_end_scan: assert property (p_end_scan) else $error("acc kept");
  a_result: assert property (p_result) else $error("bad result");
  a_pop: assert property (p_pop) else $error("pop value");
  a_pop_lvl: assert property (p_pop_lvl) else $error("pop lvl");
  a_single: assert property (p_single) else $error("word load");
  a_dbl: assert property (p_dbl) else $error("hi address");
  a_zero: assert property (p_zero) else $error("zero flag");
  a_lvl: assert property (p_lvl) else $error("level over");
  a_ld_done: assert property (p_ld_done) else $error("no done");
endmodule
bind asl_unit asl_unit_chk asl_unit_chk_inst (.*);

// >>> tb/asl_mem_model.sv
// word memory beside the unit: read data follows the strobed address
// in the strobe's own cycle, then holds the last strobed word
// word at address a reads a ^ KEY, so any address can be predicted
`timescale 1ns/10ps
module asl_mem_model #(
  parameter logic [15:0] KEY = 16'h1234
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  output logic [15:0] o_mem_rdata
);
  logic [15:0] held_q;
  // remember the last strobed address; the unit reads the final word
  // again in its commit cycle, after the strobe has dropped
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      held_q <= 16'h0000;
    end else if (i_mem_rd) begin
      held_q <= i_mem_addr;
    end
  end
  // asynchronous read: the unit captures the word at the edge that
  // closes the strobe cycle
  assign o_mem_rdata = (i_mem_rd ? i_mem_addr : held_q) ^ KEY;
endmodule

// >>> tb/tb_accumulator_stack_load_unit.sv
// testbench for the accumulator/stack load unit
// assumes the word memory model returns address ^ 16'h1234
`timescale 1ns/10ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %0t %s", $time, m); end end
module tb_accumulator_stack_load_unit;
  import asl_pkg::*;
  logic i_core_clk, i_nrst, i_op_valid, o_op_ready, o_op_done, o_mem_rd;
  logic o_accumulator_zero_flag;
  asl_op_t i_op;
  logic [15:0] i_addr, o_mem_addr, i_mem_rdata;
  logic [31:0] i_const, i_result, o_acc, o_stack_top;
  logic [3:0] o_stack_level;
  int fail_count, cmp_count;
  asl_unit asl_unit_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_addr(i_addr),
    .i_const(i_const), .i_result(i_result), .o_op_ready(o_op_ready),
    .o_op_done(o_op_done), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .i_mem_rdata(i_mem_rdata), .o_acc(o_acc), .o_stack_top(o_stack_top),
    .o_stack_level(o_stack_level),
    .o_accumulator_zero_flag(o_accumulator_zero_flag));
  asl_mem_model asl_mem_model_inst (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
    .o_mem_rdata(i_mem_rdata));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task finish_test;
    $display("counts: %0d compares, %0d fails", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one request, held for its take edge, then a bounded wait for done
  task automatic op(input asl_op_t o, input logic [15:0] a,
                    input logic [31:0] c);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_op_valid <= 1'b1;
    i_op <= o;
    i_addr <= a;
    i_const <= c;
    i_result <= c;
    @(posedge i_core_clk);
    i_op_valid <= 1'b0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_op_done !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      $display("unexpected %0t no done", $time);
      finish_test();
    end
  endtask
  task automatic chk(input logic [31:0] a, input logic [3:0] l);
    `CHK(o_acc, a, "acc value")
    `CHK(o_stack_level, l, "stack level")
  endtask
  task s_loads;
    op(ASL_OP_END_SCAN, 16'h0000, 32'h0000_0000);
    chk(32'h0000_0000, 4'h0);
    op(ASL_OP_LOAD_CONST, 16'h0000, 32'hFFFF_1234);
    chk(32'h0000_1234, 4'h0);
    op(ASL_OP_LOAD_SINGLE_WORD, 16'h0010, 32'h0000_0000);
    chk(32'h0000_1224, 4'h1);
    `CHK(o_stack_top, 32'h0000_1234, "top")
    op(ASL_OP_LOAD_DOUBLE, 16'h0020, 32'h0000_0000);
    chk(32'h1215_1214, 4'h2);
    op(ASL_OP_LOAD_POINTER, 16'h0030, 32'h0000_0000);
    chk(32'h0000_0030, 4'h3);
    op(ASL_OP_OCTAL_ADDRESS_TO_HEX_LOAD, 16'h0000, 32'h0004_0400);
    chk(32'h0000_4100, 4'h4);
    op(ASL_OP_LOAD_DOUBLE_CONST, 16'h0000, 32'h8765_4321);
    chk(32'h8765_4321, 4'h5);
    $display("test loads done");
  endtask
  task s_output;
    op(ASL_OP_OUTPUT, 16'h0000, 32'h0000_0000);
    op(ASL_OP_LOAD_CONST, 16'h0000, 32'h0000_0005);
    chk(32'h0000_0005, 4'h5);
    op(ASL_OP_LOAD_SINGLE_WORD, 16'h1234, 32'h0000_0000);
    chk(32'h0000_0000, 4'h6);
    `CHK(o_accumulator_zero_flag, 1'b1, "flag set")
    op(ASL_OP_LOAD_CONST, 16'h0000, 32'h0000_0007);
    `CHK(o_accumulator_zero_flag, 1'b0, "flag clr")
    op(ASL_OP_RESULT, 16'h0000, 32'hCAFE_0001);
    chk(32'hCAFE_0001, 4'h7);
    op(ASL_OP_END_SCAN, 16'h0000, 32'h0000_0000);
    chk(32'h0000_0000, 4'h7);
    $display("test output done");
  endtask
  task s_stack;
    repeat (9) op(ASL_OP_POP, 16'h0000, 32'h0000_0000);
    chk(32'h0000_0000, 4'h0);
    op(ASL_OP_END_SCAN, 16'h0000, 32'h0000_0000);
    for (int k = 1; k <= 10; k++) begin
      op(ASL_OP_LOAD_DOUBLE_CONST, 16'h0000, 32'(k));
    end
    chk(32'h0000_000A, 4'h8);
    for (int k = 9; k >= 2; k--) begin
      op(ASL_OP_POP, 16'h0000, 32'h0000_0000);
      `CHK(o_acc, 32'(k), "pop value")
    end
    op(ASL_OP_POP, 16'h0000, 32'h0000_0000);
    chk(32'h0000_0000, 4'h0);
    $display("test stack done");
  endtask
  initial begin
    i_nrst = 1'b0;
    i_op_valid = 1'b0;
    i_op = ASL_OP_NONE;
    i_addr = 16'h0000;
    i_const = 32'h0000_0000;
    i_result = 32'h0000_0000;
    repeat (10) @(posedge i_core_clk);
    chk(32'h0000_0000, 4'h0);
    i_nrst <= 1'b1;
    s_loads();
    s_output();
    s_stack();
    finish_test();
  end
endmodule
